// [hw/pnc_cmd.sv]
/*
 * Radio and network configuration command handler behind an APB slave.
 * Software loads payload bytes, then writes the command register; the block
 * checks fields, applies each valid network field or a fully valid radio setup, and posts a response code.
 * Assumes APB master on pclk; route events come from logic on pclk.
 */
// Notes on behaviour
// (RQ1) radio command: channel, modulation, power together
// (RQ2) any bad radio field keeps old setup
// (RQ3) channels 0,100-102 EU; 1-10 NA
// (RQ4) channel maps to fixed carrier frequency
// (RQ5) modulation zero BPSK, nonzero QPSK
// (RQ6) power max 10 NA, 5 EU; code 25
// (RQ7) codes 0 if ack, 1 short, 2 long, 24
// (RQ8) network command applies valid fields, then network reset
// (RQ9) sockets default 4; above 251 gives 26
// (RQ10) neighbor cache count zero is out of range
// (RQ11) neighbor reachable time, default 3600 s
// (RQ12) hop count default 8; zero disables mesh
// (RQ13) routing table size below one rejected
// (RQ14) route expires without revalidation in timeout
// (RQ15) route broken when failures exceed limit
// (RQ16) route refused when link signal below threshold
// (RQ17) threshold lowered by step after signal failure
// (RQ18) route request fails after attempt count
// (RQ19) address detection and solicitation flags, default true
// (RQ20) bad network fields ignored; code 29 with mask
// (RQ21) length checked against 3 or 15 bytes
`timescale 1ns/1ps
module pnc_cmd #(
	parameter int SEC_CYC = pnc_pkg::SEC_CYCLES
) (
	input  logic                 pclk,
	input  logic                 presetn,
	input  logic                 psel,
	input  logic                 penable,
	input  logic                 pwrite,
	input  logic [7:0]           paddr,
	input  logic [31:0]          pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  pnc_pkg::pnc_rt_ev_s  rt_ev,
	output pnc_pkg::pnc_radio_s  radio_cfg,
	output pnc_pkg::pnc_net_s    net_cfg,
	output logic                 mesh_en,
	output logic                 net_reset,
	output logic                 rt_up,
	output logic                 rt_broken,
	output logic                 rt_expired,
	output logic                 rt_refused,
	output logic                 rt_req_fail
);
	import pnc_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_eu(input logic [7:0] ch);
		is_eu = (ch == CH_EU0) || (ch >= CH_EU_LO && ch <= CH_EU_HI);
	endfunction

	function automatic logic is_na(input logic [7:0] ch);
		is_na = (ch >= CH_NA_LO && ch <= CH_NA_HI);
	endfunction

	function automatic logic [13:0] ch_freq(input logic [7:0] ch);
		if (ch == CH_EU0)
			ch_freq = FREQ_EU0;
		else if (is_eu(ch))
			ch_freq = FREQ_EU_LO + 14'(FREQ_EU_STEP * 14'(ch - CH_EU_LO));
		else
			ch_freq = FREQ_NA_LO + 14'(FREQ_NA_STEP * 14'(ch - CH_NA_LO));
	endfunction

	function automatic logic [7:0] pwr_max(input logic [7:0] ch);
		pwr_max = is_na(ch) ? PWR_MAX_NA : PWR_MAX_EU;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]  data_reg [DATA_BYTES];
	logic [7:0]  data_next [DATA_BYTES];
	logic        ack_reg, ack_next;
	logic [7:0]  code_reg, code_next;
	logic [15:0] mask_reg, mask_next;
	logic        rvalid_reg, rvalid_next;
	pnc_radio_s  radio_reg, radio_next;
	pnc_net_s    net_reg, net_next;
	logic        nrst_reg, nrst_next;
	logic        mesh_reg;
	logic        pready_reg, pready_next;
	logic        perr_reg, perr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        acc_wr, acc_rd, cmd_go, mapped;
	logic [7:0]  cmd_len;
	logic        cmd_net;
	logic [7:0]  thr_cur;

	assign acc_wr  = psel && penable && pready_reg && pwrite;
	assign acc_rd  = psel && penable && pready_reg && !pwrite;
	assign cmd_go  = acc_wr && (paddr == ADDR_CMD);
	assign cmd_len = pwdata[7:0];
	assign cmd_net = pwdata[CMD_SEL_BIT];
	assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= ADDR_ROUTE);

	// ----------------------------------------------------------------
	// bus slave: one wait-free access phase, read data built at setup
	// ----------------------------------------------------------------
	always_comb begin
		pready_next = psel && !penable;
		perr_next = psel && !penable && !mapped;
		prdata_next = 32'h0;
		if (psel && !penable && !pwrite) begin
			if (paddr >= ADDR_DATA0 && paddr <= ADDR_DATA3 && paddr[1:0] == 2'b00) begin
				for (int i = 0; i < 4; i++)
					prdata_next[8*i +: 8] = data_reg[4*(paddr[4:2] - 3'd2) + i];
			end else begin
				case (paddr)
					ADDR_CTRL:  prdata_next = {31'h0, ack_reg};
					ADDR_RESP:  prdata_next = {7'h0, rvalid_reg, mask_reg, code_reg};
					ADDR_RADIO: prdata_next = {8'h0, radio_reg.power, 7'h0, radio_reg.qpsk, radio_reg.chan};
					ADDR_FREQ:  prdata_next = {18'h0, radio_reg.freq};
					ADDR_NET0:  prdata_next = {net_reg.fail_lim, net_reg.hops, net_reg.cache, net_reg.sock};
					ADDR_NET1:  prdata_next = {net_reg.table_size, net_reg.reach};
					ADDR_NET2:  prdata_next = {net_reg.rssi_red, net_reg.min_rssi, net_reg.timeout};
					ADDR_NET3:  prdata_next = {22'h0, net_reg.rsol, net_reg.dad, net_reg.attempts};
					ADDR_ROUTE: prdata_next = {16'h0, thr_cur, 3'h0, rt_req_fail, rt_refused,
						rt_expired, rt_broken, rt_up};
					default:    prdata_next = 32'h0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// command execution and register writes
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < DATA_BYTES; i++)
			data_next[i] = data_reg[i];
		ack_next = ack_reg;
		code_next = code_reg;
		mask_next = mask_reg;
		rvalid_next = rvalid_reg;
		radio_next = radio_reg;
		net_next = net_reg;
		nrst_next = 1'b0;
		// reading the response retires it; a new response below wins
		if (acc_rd && paddr == ADDR_RESP)
			rvalid_next = 1'b0;
		if (acc_wr && paddr == ADDR_CTRL)
			ack_next = pwdata[0];
		if (acc_wr && paddr >= ADDR_DATA0 && paddr <= ADDR_DATA3 && paddr[1:0] == 2'b00) begin
			for (int i = 0; i < 4; i++)
				data_next[4*(paddr[4:2] - 3'd2) + i] = pwdata[8*i +: 8];
		end
		if (cmd_go) begin
			mask_next = 16'h0;
			code_next = RC_OK;
			if (cmd_len < (cmd_net ? NET_LEN : RADIO_LEN))
				code_next = RC_SHORT; // see (RQ21) (RQ7)
			else if (cmd_len > (cmd_net ? NET_LEN : RADIO_LEN))
				code_next = RC_LONG; // see (RQ21) (RQ7)
			else if (!cmd_net) begin
				// byte 0 channel, byte 1 modulation, byte 2 power
				if (!is_eu(data_reg[0]) && !is_na(data_reg[0]))
					code_next = RC_BAD_CHAN; // see (RQ3) (RQ7)
				else if (data_reg[2] > pwr_max(data_reg[0]))
					code_next = RC_BAD_POWER; // see (RQ6)
				else begin
					radio_next.chan = data_reg[0]; // see (RQ1)
					radio_next.qpsk = (data_reg[1] != 8'h0); // see (RQ5)
					radio_next.power = data_reg[2];
					radio_next.freq = ch_freq(data_reg[0]); // see (RQ4)
				end
				// see (RQ2): radio_next untouched on any failure above
			end else begin
				// multi-byte fields are little-endian
				if (data_reg[0] > SOCK_MAX)
					mask_next[0] = 1'b1; // see (RQ9)
				else
					net_next.sock = data_reg[0];
				if (data_reg[1] == 8'h0)
					mask_next[1] = 1'b1; // see (RQ10)
				else
					net_next.cache = data_reg[1];
				net_next.reach = {data_reg[3], data_reg[2]}; // see (RQ11)
				net_next.hops = data_reg[4]; // see (RQ12)
				if ({data_reg[6], data_reg[5]} == 16'h0)
					mask_next[4] = 1'b1; // see (RQ13)
				else
					net_next.table_size = {data_reg[6], data_reg[5]};
				net_next.timeout = {data_reg[8], data_reg[7]}; // see (RQ14)
				net_next.fail_lim = data_reg[9];
				net_next.min_rssi = data_reg[10];
				net_next.rssi_red = data_reg[11];
				net_next.attempts = data_reg[12];
				net_next.dad = (data_reg[13] != 8'h0); // see (RQ19)
				net_next.rsol = (data_reg[14] != 8'h0); // see (RQ19)
				nrst_next = 1'b1; // see (RQ8)
			end
			if (cmd_net && cmd_len == NET_LEN) begin
				if (mask_next == 16'h0001)
					code_next = RC_SOCK_HIGH; // see (RQ9)
				else if (mask_next != 16'h0)
					code_next = RC_NET_RANGE; // see (RQ20)
			end
			rvalid_next = (code_next != RC_OK) || ack_reg; // see (RQ7)
		end
	end

	// register all handler state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DATA_BYTES; i++)
				data_reg[i] <= 8'h0;
			ack_reg <= 1'b1;
			code_reg <= RC_OK;
			mask_reg <= 16'h0;
			rvalid_reg <= 1'b0;
			radio_reg <= '{CH_EU0, 1'b0, 8'h0, FREQ_EU0};
			net_reg <= NET_RST;
			nrst_reg <= 1'b0;
			mesh_reg <= 1'b1;
			pready_reg <= 1'b0;
			perr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			for (int i = 0; i < DATA_BYTES; i++)
				data_reg[i] <= data_next[i];
			ack_reg <= ack_next;
			code_reg <= code_next;
			mask_reg <= mask_next;
			rvalid_reg <= rvalid_next;
			radio_reg <= radio_next;
			net_reg <= net_next;
			nrst_reg <= nrst_next;
			mesh_reg <= (net_next.hops != 8'h0); // see (RQ12)
			pready_reg <= pready_next;
			perr_reg <= perr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = perr_reg;
	assign radio_cfg = radio_reg;
	assign net_cfg   = net_reg;
	assign mesh_en   = mesh_reg;
	assign net_reset = nrst_reg;

	// ----------------------------------------------------------------
	// route policy, reloaded by each network reset
	// ----------------------------------------------------------------
	pnc_route #(
		.SEC_CYC (SEC_CYC)
	) u_route (
		.pclk         (pclk),
		.presetn      (presetn),
		.cfg          (net_reg),
		.cfg_load     (nrst_reg),
		.ev           (rt_ev),
		.up_reg       (rt_up),
		.broken_reg   (rt_broken),
		.expired_reg  (rt_expired),
		.refused_reg  (rt_refused),
		.req_fail_reg (rt_req_fail),
		.thr_reg      (thr_cur)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_ch0_freq;
		@(posedge pclk) disable iff (!presetn)
		(radio_reg.chan == CH_EU0) |-> (radio_reg.freq == 14'h21eb);
	endproperty
	a_ch0_freq: assert property (p_ch0_freq) else $error("channel 0 frequency wrong"); // see (RQ4)

	property p_radio_hold;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && !cmd_net && !is_eu(data_reg[0]) && !is_na(data_reg[0])) |=> $stable(radio_reg);
	endproperty
	a_radio_hold: assert property (p_radio_hold) else $error("radio changed on bad command"); // see (RQ2)

	property p_code24;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && !cmd_net && cmd_len == 8'h03 && !is_eu(data_reg[0]) && !is_na(data_reg[0]))
		|=> (code_reg == 8'h18 && rvalid_reg);
	endproperty
	a_code24: assert property (p_code24) else $error("bad channel not answered 24"); // see (RQ3)

	property p_power;
		@(posedge pclk) disable iff (!presetn)
		radio_reg.power <= (is_na(radio_reg.chan) ? 8'h0a : 8'h05);
	endproperty
	a_power: assert property (p_power) else $error("power above channel limit"); // see (RQ6)

	property p_short;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && !cmd_net && cmd_len < 8'h03) |=> (code_reg == 8'h01 && rvalid_reg && $stable(radio_reg));
	endproperty
	a_short: assert property (p_short) else $error("short frame not answered 1"); // see (RQ7)

	property p_netrst;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && cmd_net && cmd_len == 8'h0f) |=> nrst_reg ##1 !nrst_reg;
	endproperty
	a_netrst: assert property (p_netrst) else $error("network reset not pulsed"); // see (RQ8)

	property p_limits;
		@(posedge pclk) disable iff (!presetn)
		net_reg.sock <= 8'hfb && net_reg.cache != 8'h0 && net_reg.table_size != 16'h0;
	endproperty
	a_limits: assert property (p_limits) else $error("out of range parameter applied"); // see (RQ10)

	property p_mask;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && cmd_net && cmd_len == 8'h0f && data_reg[1] == 8'h0 && data_reg[5] == 8'h0 && data_reg[6] == 8'h0)
		|=> (code_reg == 8'h1d && mask_reg[4] && mask_reg[1]);
	endproperty
	a_mask: assert property (p_mask) else $error("range failure mask wrong"); // see (RQ20)

	property p_mesh;
		@(posedge pclk) disable iff (!presetn)
		(cmd_go && cmd_net && cmd_len == 8'h0f) |=> (mesh_reg == ($past(data_reg[4]) != 8'h0));
	endproperty
	a_mesh: assert property (p_mesh) else $error("mesh enable disagrees with hops"); // see (RQ12)
endmodule

// [hw/pnc_pkg.sv]
/*
 * Shared constants and carriers for the radio and network configuration
 * command handler: register offsets, reset values, response codes, timing.
 * Assumes a 200 MHz pclk and a 32-bit APB register bus.
 */
package pnc_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_CMD   = 8'h04;
	localparam logic [7:0] ADDR_DATA0 = 8'h08;
	localparam logic [7:0] ADDR_DATA3 = 8'h14;
	localparam logic [7:0] ADDR_RESP  = 8'h1c;
	localparam logic [7:0] ADDR_RADIO = 8'h20;
	localparam logic [7:0] ADDR_FREQ  = 8'h24;
	localparam logic [7:0] ADDR_NET0  = 8'h28;
	localparam logic [7:0] ADDR_NET1  = 8'h2c;
	localparam logic [7:0] ADDR_NET2  = 8'h30;
	localparam logic [7:0] ADDR_NET3  = 8'h34;
	localparam logic [7:0] ADDR_ROUTE = 8'h38;
	localparam int         CMD_SEL_BIT = 8;
	localparam int         DATA_BYTES  = 16;
	// ----------------------------------------------------------------
	// payload lengths and response codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RADIO_LEN     = 8'h03;
	localparam logic [7:0] NET_LEN       = 8'h0f;
	localparam logic [7:0] RC_OK         = 8'h00;
	localparam logic [7:0] RC_SHORT      = 8'h01;
	localparam logic [7:0] RC_LONG       = 8'h02;
	localparam logic [7:0] RC_BAD_CHAN   = 8'h18;
	localparam logic [7:0] RC_BAD_POWER  = 8'h19;
	localparam logic [7:0] RC_SOCK_HIGH  = 8'h1a;
	localparam logic [7:0] RC_NET_RANGE  = 8'h1d;
	// ----------------------------------------------------------------
	// field limits
	// ----------------------------------------------------------------
	localparam logic [7:0]  CH_EU0      = 8'h00;
	localparam logic [7:0]  CH_EU_LO    = 8'h64;
	localparam logic [7:0]  CH_EU_HI    = 8'h66;
	localparam logic [7:0]  CH_NA_LO    = 8'h01;
	localparam logic [7:0]  CH_NA_HI    = 8'h0a;
	localparam logic [7:0]  PWR_MAX_NA  = 8'h0a;
	localparam logic [7:0]  PWR_MAX_EU  = 8'h05;
	localparam logic [7:0]  SOCK_MAX    = 8'hfb;
	// carrier frequency in units of 100 kHz
	localparam logic [13:0] FREQ_EU0    = 14'h21eb;
	localparam logic [13:0] FREQ_EU_LO  = 14'h21cd;
	localparam logic [13:0] FREQ_NA_LO  = 14'h2364;
	localparam logic [13:0] FREQ_EU_STEP = 14'h000a;
	localparam logic [13:0] FREQ_NA_STEP = 14'h0014;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_SOCK    = 8'h04;
	localparam logic [7:0]  RST_CACHE   = 8'h04;
	localparam logic [15:0] RST_REACH   = 16'h0e10;
	localparam logic [7:0]  RST_HOPS    = 8'h08;
	localparam logic [15:0] RST_TABLE   = 16'h0008;
	localparam logic [15:0] RST_TIMEOUT = 16'h0e10;
	localparam logic [7:0]  RST_FAIL    = 8'h03;
	localparam logic [7:0]  RST_RSSI    = 8'h80;
	localparam logic [7:0]  RST_RED     = 8'h00;
	localparam logic [7:0]  RST_ATTEMPT = 8'h03;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int SEC_NS        = 1000000000;
	localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  chan;
		logic        qpsk;
		logic [7:0]  power;
		logic [13:0] freq;
	} pnc_radio_s;
	typedef struct packed {
		logic [7:0]  sock;
		logic [7:0]  cache;
		logic [15:0] reach;
		logic [7:0]  hops;
		logic [15:0] table_size;
		logic [15:0] timeout;
		logic [7:0]  fail_lim;
		logic [7:0]  min_rssi;
		logic [7:0]  rssi_red;
		logic [7:0]  attempts;
		logic        dad;
		logic        rsol;
	} pnc_net_s;
	typedef struct packed {
		logic       fwd_fail;
		logic       traffic;
		logic       setup;
		logic [7:0] link_rssi;
	} pnc_rt_ev_s;
	localparam pnc_net_s NET_RST = '{RST_SOCK, RST_CACHE, RST_REACH, RST_HOPS,
		RST_TABLE, RST_TIMEOUT, RST_FAIL, RST_RSSI, RST_RED, RST_ATTEMPT, 1'b1, 1'b1};
endpackage

// [hw/pnc_route.sv]
/*
 * Single-route policy tracker: expiry, failure limit, signal threshold with
 * reduction, and request attempt limit.
 * Assumes events arrive as one-cycle pulses on pclk from the network stack.
 */
`timescale 1ns/1ps
module pnc_route #(
	parameter int SEC_CYC = pnc_pkg::SEC_CYCLES
) (
	input  logic              pclk,
	input  logic              presetn,
	input  pnc_pkg::pnc_net_s cfg,
	input  logic              cfg_load,
	input  pnc_pkg::pnc_rt_ev_s ev,
	output logic              up_reg,
	output logic              broken_reg,
	output logic              expired_reg,
	output logic              refused_reg,
	output logic              req_fail_reg,
	output logic [7:0]        thr_reg
);
	import pnc_pkg::*;
	typedef enum logic [0:0] {RT_IDLE = 1'b0, RT_UP = 1'b1} pnc_rt_e;
	pnc_rt_e     st_reg, st_next;
	logic [31:0] tick_reg, tick_next;
	logic [15:0] age_reg, age_next;
	logic [7:0]  fails_reg, fails_next, tries_reg, tries_next, thr_next;
	logic        brk_next, exp_next, ref_next, rqf_next;

	// route life and threshold next state
	always_comb begin
		st_next = st_reg;
		tick_next = tick_reg + 32'h1;
		age_next = age_reg;
		fails_next = fails_reg;
		tries_next = tries_reg;
		thr_next = thr_reg;
		brk_next = 1'b0;
		exp_next = 1'b0;
		ref_next = 1'b0;
		rqf_next = 1'b0;
		if (tick_reg >= 32'(SEC_CYC - 1)) begin
			tick_next = 32'h0;
			age_next = age_reg + 16'h1;
		end
		case (st_reg)
			RT_IDLE: begin
				if (ev.setup) begin
					if ($signed(ev.link_rssi) < $signed(thr_reg)) begin // see (RQ16)
						ref_next = 1'b1;
						thr_next = ($signed(thr_reg) - $signed({1'b0, cfg.rssi_red}) < -128) ?
							8'h80 : 8'(thr_reg - cfg.rssi_red); // see (RQ17)
						tries_next = tries_reg + 8'h1;
						if (tries_reg + 8'h1 >= cfg.attempts) begin // see (RQ18)
							rqf_next = 1'b1;
							tries_next = 8'h0;
						end
					end else begin
						st_next = RT_UP;
						tries_next = 8'h0;
						age_next = 16'h0;
						tick_next = 32'h0;
						fails_next = 8'h0;
					end
				end
			end
			RT_UP: begin
				if (ev.traffic) begin
					age_next = 16'h0;
					tick_next = 32'h0;
				end
				if (ev.fwd_fail) begin
					fails_next = fails_reg + 8'h1;
					if (fails_reg >= cfg.fail_lim) begin // see (RQ15)
						brk_next = 1'b1;
						st_next = RT_IDLE;
					end
				end else if (!ev.traffic && age_reg >= cfg.timeout) begin // see (RQ14)
					exp_next = 1'b1;
					st_next = RT_IDLE;
				end
			end
			default: st_next = RT_IDLE;
		endcase
		if (cfg_load) begin
			st_next = RT_IDLE;
			thr_next = cfg.min_rssi;
			tries_next = 8'h0;
		end
	end

	// register the route state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= RT_IDLE;
			tick_reg <= 32'h0;
			age_reg <= 16'h0;
			fails_reg <= 8'h0;
			tries_reg <= 8'h0;
			thr_reg <= RST_RSSI;
			up_reg <= 1'b0;
			broken_reg <= 1'b0;
			expired_reg <= 1'b0;
			refused_reg <= 1'b0;
			req_fail_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			tick_reg <= tick_next;
			age_reg <= age_next;
			fails_reg <= fails_next;
			tries_reg <= tries_next;
			thr_reg <= thr_next;
			up_reg <= (st_next == RT_UP);
			broken_reg <= brk_next;
			expired_reg <= exp_next;
			refused_reg <= ref_next;
			req_fail_reg <= rqf_next;
		end
	end

	property p_broken;
		@(posedge pclk) disable iff (!presetn)
		(st_reg == RT_UP && ev.fwd_fail && fails_reg >= cfg.fail_lim && !cfg_load) |=> (broken_reg && !up_reg);
	endproperty
	a_broken: assert property (p_broken) else $error("route not removed at failure limit"); // see (RQ15)

	property p_refuse;
		@(posedge pclk) disable iff (!presetn)
		(st_reg == RT_IDLE && ev.setup && $signed(ev.link_rssi) < $signed(thr_reg) && !cfg_load)
		|=> (refused_reg && !up_reg);
	endproperty
	a_refuse: assert property (p_refuse) else $error("weak route was established"); // see (RQ16)
endmodule

// [verif/pnc_stack_model.sv]
/* network stack stand-in: emits route event pulses on request.
   assumes bench raises go {fwd_fail, traffic, setup} for one cycle, after a pclk edge. */
`timescale 1ns/1ps
module pnc_stack_model (
	input  logic                pclk,
	input  logic                presetn,
	input  logic [2:0]          go,
	input  logic [7:0]          rssi,
	output pnc_pkg::pnc_rt_ev_s ev
);
	import pnc_pkg::*;
	// one-cycle setup with link strength; strength inverted when not valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev <= '0;
		end else begin
			ev <= '{go[2], go[1], go[0], go[0] ? rssi : ~rssi};
		end
	end
endmodule

// [verif/testbench.sv]
/* self-checking bench for the configuration command handler.
   assumes an apb slave; the master waits for pready, bounded by the hang guard. */
`timescale 1ns/1ps
module testbench;
	import pnc_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and checks
	// ----------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, mesh_en, net_reset, rt_refused;
	logic        rt_up, rt_broken, rt_expired, rt_req_fail;
	logic [2:0]  go;
	logic [7:0]  paddr, rssi;
	logic [31:0] pwdata, prdata, rd;
	pnc_rt_ev_s  ev;
	pnc_radio_s  radio_cfg;
	pnc_net_s    net_cfg;
	int          mismatches = 0, samples_checked = 0, cycles = 0, resets = 0, refusals = 0, r;
	int          breaks = 0, expiries = 0, req_fails = 0;
	localparam logic [127:0] NET_OK = 128'h00010305f6030e100008000e100404;
	pnc_stack_model pnc_stack_model_i (.pclk(pclk), .presetn(presetn), .go(go), .rssi(rssi), .ev(ev));
	pnc_cmd #(.SEC_CYC(10)) pnc_cmd_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rt_ev(ev), .radio_cfg(radio_cfg), .net_cfg(net_cfg), .mesh_en(mesh_en), .net_reset(net_reset),
		.rt_up(rt_up), .rt_broken(rt_broken), .rt_expired(rt_expired), .rt_refused(rt_refused),
		.rt_req_fail(rt_req_fail));
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	// pulse counters and hang guard
	always @(posedge pclk) begin
		cycles++;
		resets += int'(net_reset === 1'b1);
		refusals += int'(rt_refused === 1'b1);
		breaks += int'(rt_broken === 1'b1);
		expiries += int'(rt_expired === 1'b1);
		req_fails += int'(rt_req_fail === 1'b1);
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; request held until the rising edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// load payload, issue command, read response into rd
	task automatic cmd(input logic [127:0] p, input logic [7:0] len, input logic net);
		for (int k = 0; k < 4; k++) apb(1'b1, ADDR_DATA0 + 8'(4 * k), p[32 * k +: 32]);
		apb(1'b1, ADDR_CMD, {23'h0, net, len});
		apb(1'b0, ADDR_RESP, 32'h0);
	endtask
	task automatic test_reset();
		apb(1'b0, ADDR_RADIO, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, ADDR_FREQ, 32'h0);
		check(rd, 32'h21eb);
		apb(1'b0, ADDR_NET0, 32'h0);
		check(rd, 32'h03080404);
		apb(1'b0, ADDR_NET3, 32'h0);
		check(rd, 32'h0303);
	endtask
	task automatic test_radio();
		cmd(128'h050766, 8'h03, 1'b0);
		check(rd, 32'h01000000);
		check({15'h0, radio_cfg.power, radio_cfg.qpsk, radio_cfg.chan}, 32'h00000b66);
		check({18'h0, radio_cfg.freq}, 32'h21e1);
		cmd(128'h060065, 8'h03, 1'b0);
		check(rd, 32'h01000019);
		cmd(128'h00000b, 8'h03, 1'b0);
		check(rd, 32'h01000018);
		check({24'h0, radio_cfg.chan}, 32'h66);
		cmd(128'h0a000a, 8'h03, 1'b0);
		check({18'h0, radio_cfg.freq}, 32'h2418);
		cmd(128'h0a000a, 8'h02, 1'b0);
		check(rd, 32'h01000001);
		cmd(128'h0a000a, 8'h04, 1'b0);
		check(rd, 32'h01000002);
		apb(1'b1, ADDR_CTRL, 32'h0);
		cmd(128'h0, 8'h03, 1'b0);
		check(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
	endtask
	task automatic test_net();
		r = resets;
		cmd(NET_OK, 8'h0f, 1'b0 | 1'b1);
		check(rd, 32'h01000000);
		check(32'(resets - r), 32'h1);
		check({31'h0, mesh_en}, 32'h0);
		apb(1'b0, ADDR_NET1, 32'h0);
		check(rd, 32'h00080e10);
		go <= 3'b001;
		rssi <= 8'hec;
		@(posedge pclk);
		go <= 3'b000;
		repeat (4) @(posedge pclk);
		check(32'(refusals), 32'h1);
		apb(1'b0, ADDR_ROUTE, 32'h0);
		check({24'h0, rd[15:8]}, 32'hf1);
		cmd({NET_OK[127:8], 8'hfc}, 8'h0f, 1'b1);
		check(rd & 32'h010000ff, 32'h0100001a);
		check({24'h0, net_cfg.sock}, 32'h4);
		cmd({NET_OK[127:56], 16'h0, NET_OK[39:16], 8'h0, NET_OK[7:0]}, 8'h0f, 1'b1);
		check(rd, 32'h0100121d);
		r = resets;
		cmd(NET_OK, 8'h0e, 1'b1);
		check(rd, 32'h01000001);
		check(32'(resets - r), 32'h0);
	endtask
	// one event pulse from the stack model, then let the route answer settle
	task automatic ev_pulse(input logic [2:0] k, input logic [7:0] s);
		go <= k;
		rssi <= s;
		@(posedge pclk);
		go <= 3'b000;
		repeat (3) @(posedge pclk);
	endtask
	// attempt limit, failure limit and expiry with a two-second route timeout
	task automatic test_route();
		cmd({NET_OK[127:72], 16'h0002, NET_OK[55:0]}, 8'h0f, 1'b1);
		check(rd, 32'h01000000);
		repeat (2) ev_pulse(3'b001, 8'h80);
		check(32'(req_fails), 32'h0);
		ev_pulse(3'b001, 8'h80);
		check(32'(req_fails), 32'h1);
		apb(1'b0, ADDR_ROUTE, 32'h0);
		check({24'h0, rd[15:8]}, 32'he7);
		ev_pulse(3'b001, 8'h00);
		check({31'h0, rt_up}, 32'h1);
		repeat (3) ev_pulse(3'b110, 8'h00);
		check(32'(breaks), 32'h0);
		ev_pulse(3'b110, 8'h00);
		check(32'(breaks), 32'h1);
		check({31'h0, rt_up}, 32'h0);
		ev_pulse(3'b001, 8'h00);
		repeat (12) @(posedge pclk);
		check(32'(expiries), 32'h0);
		check({31'h0, rt_up}, 32'h1);
		repeat (12) @(posedge pclk);
		check(32'(expiries), 32'h1);
		check({31'h0, rt_up}, 32'h0);
	endtask
	task automatic test_bus();
		apb(1'b0, 8'h3c, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		presetn = 0;
		{psel, penable, pwrite, go, paddr, rssi, pwdata} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_radio();
		test_net();
		test_route();
		test_bus();
		report_and_stop();
	end
endmodule
